// >>> inc/cfg_pkg.sv
// Notes on behaviour
// RULE1 - sample all switches at reset, hold until next
// RULE2 - switch 1 at power-up erases storage
// RULE3 - reset jumper erases at power-up and reset-low
// RULE4 - switch 2 enables XON/XOFF flow control
// RULE5 - switch 3 enables hardware handshake flow
// RULE6 - switches 4,5,6 select the serial rate
// RULE7 - switch 10 routes messages to USB
// RULE8 - prompt goes to message port after update
// RULE9 - upgrade jumper forces firmware reload acceptance
// RULE10 - stepper jumper plus motor-type command selects stepping
// RULE11 - motor-off jumper holds motors off until enabled
// RULE12 - power up as servo, one DAC per axis
// RULE13 - sine axis borrows highest free DAC
// RULE14 - each sine axis that finds a free DAC above its own removes one addressable axis
// RULE15 - serial frame 8N1, full duplex, both ends
// RULE16 - unlisted rate pattern falls back to default
package cfg_pkg;
    // clock and settle timing
    localparam int CLK_HZ        = 125_000_000;
    localparam int CLK_PERIOD_PS = 8000;
    localparam int SETTLE_NS     = 100;          // pin pipeline settle time
    localparam int SETTLE_CYC    = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W         = 4;

    // axes
    localparam int AXES = 8;
    localparam int AX_W = 3;
    localparam int CNT_AX_W = 4;

    // switch positions (switch n sits at index n-1)
    localparam int NUM_SW     = 10;
    localparam int SW_ERASE   = 0;
    localparam int SW_XON     = 1;
    localparam int SW_HWHS    = 2;
    localparam int SW_BAUD_A  = 3;
    localparam int SW_BAUD_B  = 4;
    localparam int SW_BAUD_C  = 5;
    localparam int SW_USB     = 9;

    // rate patterns as {switch4, switch5, switch6}
    localparam logic [2:0] PAT_1200   = 3'h6;
    localparam logic [2:0] PAT_9600   = 3'h4;
    localparam logic [2:0] PAT_19200  = 3'h2;
    localparam logic [2:0] PAT_38400  = 3'h1;
    localparam logic [2:0] PAT_115200 = 3'h3;

    localparam int DIV_W = 17;
    localparam logic [DIV_W-1:0] DIV_1200   = DIV_W'(CLK_HZ / 1200);
    localparam logic [DIV_W-1:0] DIV_9600   = DIV_W'(CLK_HZ / 9600);
    localparam logic [DIV_W-1:0] DIV_19200  = DIV_W'(CLK_HZ / 19200);
    localparam logic [DIV_W-1:0] DIV_38400  = DIV_W'(CLK_HZ / 38400);
    localparam logic [DIV_W-1:0] DIV_115200 = DIV_W'(CLK_HZ / 115200);

    // serial framing
    localparam logic [3:0] FRAME_DATA_BITS = 4'h8;
    localparam logic [1:0] FRAME_STOP_BITS = 2'h1;
    localparam logic       FRAME_PARITY    = 1'b0;
    localparam logic [7:0] PROMPT_CHAR     = 8'h3A;

    // register map
    localparam int ADDR_W = 6;
    localparam logic [ADDR_W-1:0] REG_STATUS = 6'h00;
    localparam logic [ADDR_W-1:0] REG_CTRL   = 6'h04;
    localparam logic [ADDR_W-1:0] REG_MTYPE  = 6'h08;
    localparam logic [ADDR_W-1:0] REG_SINE   = 6'h0C;
    localparam logic [ADDR_W-1:0] REG_AXES   = 6'h10;
    localparam logic [ADDR_W-1:0] REG_DACMAP = 6'h14;
    localparam int CTRL_SERVO_EN  = 0;
    localparam int CTRL_MOTOR_OFF = 1;

    typedef enum logic [2:0] {baud_1200, baud_9600, baud_19200, baud_38400, baud_115200} baud_t;
    typedef enum logic [1:0] {st_settle, st_sample, st_run} cfg_state_t;

    // configuration pins as one bundle
    typedef struct packed {
        logic                reset_in_n;
        logic                motor_off_select;
        logic                firmware_upgrade_jumper;
        logic                master_reset_jumper;
        logic [AXES-1:0]     stepper_mode_jumper;
        logic [NUM_SW-1:0]   sw;
    } pin_t;
    localparam int PIN_W = $bits(pin_t);

    typedef struct packed {
        logic                xon_en;
        logic                hwhs_en;
        baud_t               rate;
        logic [DIV_W-1:0]    div;
        logic [3:0]          data_bits;
        logic [1:0]          stop_bits;
        logic                parity_en;
    } uart_cfg_t;

    typedef struct packed {
        logic [AXES-1:0]           borrowed;
        logic [AXES-1:0]           addressable;
        logic [CNT_AX_W-1:0]       count;
        logic [AXES-1:0][AX_W-1:0] second_dac;
    } dac_map_t;
endpackage

// >>> logic/pin_sync.sv
`timescale 1ns/1ps
module pin_sync
(
    input  wire logic                 clock,
    input  wire logic                 nrst,
    input  wire logic [cfg_pkg::PIN_W-1:0] pins_raw,
    output logic      [cfg_pkg::PIN_W-1:0] pins_stable
);
    import cfg_pkg::*;

    // three-stage pipeline plus the accepted value
    typedef struct packed {
        logic [PIN_W-1:0] s1;
        logic [PIN_W-1:0] s2;
        logic [PIN_W-1:0] s3;
        logic [PIN_W-1:0] stable;
    } sync_st_t;

    sync_st_t st_ff;
    sync_st_t nxt_st;

    // a bit is taken only when stages two and three agree
    always_comb
    begin
        nxt_st        = st_ff;
        nxt_st.s1     = pins_raw;
        nxt_st.s2     = st_ff.s1;
        nxt_st.s3     = st_ff.s2;
        nxt_st.stable = ((st_ff.s2 ~^ st_ff.s3) & st_ff.s2) | ((st_ff.s2 ^ st_ff.s3) & st_ff.stable);
    end

    // reset to all zero; the loader waits out the settle time anyway
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign pins_stable = st_ff.stable;
endmodule // pin_sync

// >>> logic/powerup_config_sampler.sv
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module powerup_config_sampler
(
    input  wire logic                          clock,
    input  wire logic                          nrst,
    // raw pins from the installer side
    input  wire cfg_pkg::pin_t                 pins_raw,
    // firmware side status, same clock
    input  wire logic                          nvm_image_ok,
    input  wire logic                          fw_update_done,
    // register port
    input  wire logic [cfg_pkg::ADDR_W-1:0]    addr,
    input  wire logic [31:0]                   wdata,
    input  wire logic                          wr_stb,
    input  wire logic                          rd_stb,
    output logic      [31:0]                   rdata,
    // configuration results
    output cfg_pkg::uart_cfg_t                 uart_cfg,
    output logic                               msg_port_usb,
    output logic                               nvm_erase_all,
    output logic                               fw_load_accept,
    output logic [cfg_pkg::AXES-1:0]           step_dir_axes,
    output logic                               motor_enable,
    output cfg_pkg::dac_map_t                  dac_map,
    output logic                               prompt_valid,
    output logic [7:0]                         prompt_char,
    output logic                               prompt_to_usb,
    output logic                               cfg_ready
);
    import cfg_pkg::*;

    // whole state of the loader
    typedef struct packed {
        cfg_state_t         state;       // loader phase
        logic [CNT_W-1:0]   cnt;         // settle counter
        logic               pwr_up;      // first sample after power-on
        logic               rin_prev;    // reset pin, last cycle
        pin_t               cap;         // captured pins
        uart_cfg_t          uart;        // serial setup
        logic               msg_usb;     // message port select
        logic               erase;       // erase pulse
        logic               fw_ok;       // reload acceptance
        logic [AXES-1:0]    type_mask;   // motor-type stepper request
        logic [AXES-1:0]    sine_mask;   // sinusoidal axes request
        logic [AXES-1:0]    step_axes;   // active stepper axes
        logic               motor_en;    // motor power state
        dac_map_t           map;         // dac assignment
        logic               prompt_v;    // prompt pulse
        logic               prompt_usb;  // prompt target
        logic [31:0]        rd;          // read data
        logic               ready;       // run phase, kept as a flop
    } cfg_st_t;

    cfg_st_t st_ff;
    cfg_st_t nxt_st;
    pin_t    pins;                       // synchronised pins

    // pins cross into this clock through the three-stage filter
    pin_sync u_sync
    (
        .clock       (clock),
        .nrst        (nrst),
        .pins_raw    (pins_raw),
        .pins_stable (pins)
    );

    // rate decode; an unlisted pattern falls back to 19200 so the port never runs at a random rate
    function automatic uart_cfg_t decode_uart(input logic [NUM_SW-1:0] sw);
        uart_cfg_t  u;
        logic [2:0] pat;
        u           = '0;
        pat         = {sw[SW_BAUD_A], sw[SW_BAUD_B], sw[SW_BAUD_C]};
        u.xon_en    = sw[SW_XON];                        // RULE4
        u.hwhs_en   = sw[SW_HWHS];                       // RULE5
        u.data_bits = FRAME_DATA_BITS;                   // RULE15
        u.stop_bits = FRAME_STOP_BITS;                   // RULE15
        u.parity_en = FRAME_PARITY;                      // RULE15
        if (pat == PAT_1200)
        begin
            u.rate = baud_1200;                          // RULE6
            u.div  = DIV_1200;
        end
        else if (pat == PAT_9600)
        begin
            u.rate = baud_9600;                          // RULE6
            u.div  = DIV_9600;
        end
        else if (pat == PAT_19200)
        begin
            u.rate = baud_19200;                         // RULE6
            u.div  = DIV_19200;
        end
        else if (pat == PAT_38400)
        begin
            u.rate = baud_38400;                         // RULE6
            u.div  = DIV_38400;
        end
        else if (pat == PAT_115200)
        begin
            u.rate = baud_115200;                        // RULE6
            u.div  = DIV_115200;
        end
        else
        begin
            u.rate = baud_19200;                         // RULE16
            u.div  = DIV_19200;
        end
        return u;
    endfunction

    // dac planner: sine axes in ascending order each take the highest dac above their own that is
    // neither borrowed nor the own dac of another sine axis
    function automatic dac_map_t plan_dacs(input logic [AXES-1:0] sine);
        dac_map_t m;
        logic     found;
        m = '0;
        for (int i = 0; i < AXES; i++)
        begin
            m.second_dac[i] = AX_W'(i);                  // RULE12
        end
        for (int i = 0; i < AXES; i++)
        begin
            found = 1'b0;
            if (sine[i] && !m.borrowed[i])
            begin
                for (int k = AXES - 1; k > i; k--)
                begin
                    if (!found && !m.borrowed[k] && !sine[k])
                    begin
                        found           = 1'b1;
                        m.borrowed[k]   = 1'b1;          // RULE13
                        m.second_dac[i] = AX_W'(k);      // RULE13
                    end
                end
            end
        end
        m.addressable = ~m.borrowed;                     // RULE14
        m.count       = '0;
        for (int i = 0; i < AXES; i++)
        begin
            if (m.addressable[i])
                m.count = m.count + CNT_AX_W'(1);        // RULE14
        end
        return m;
    endfunction

    // loader sequence, register port and run-time commands
    always_comb
    begin
        nxt_st          = st_ff;
        nxt_st.erase    = 1'b0;
        nxt_st.prompt_v = 1'b0;
        nxt_st.rd       = '0;
        nxt_st.rin_prev = pins.reset_in_n;

        case (st_ff.state)
            st_settle:
            begin
                // wait while the reset pin is held low, then let the pins settle
                if (!pins.reset_in_n)
                    nxt_st.cnt = '0;
                else if (st_ff.cnt == CNT_W'(SETTLE_CYC - 1))
                    nxt_st.state = st_sample;
                else
                    nxt_st.cnt = st_ff.cnt + CNT_W'(1);
            end
            st_sample:
            begin
                // one snapshot, held until the next reset
                nxt_st.cap      = pins;                              // RULE1
                nxt_st.uart     = decode_uart(pins.sw);              // RULE1
                nxt_st.msg_usb  = pins.sw[SW_USB];                   // RULE7
                nxt_st.motor_en = !pins.motor_off_select;            // RULE11
                nxt_st.type_mask = '0;
                nxt_st.sine_mask = '0;                               // RULE12
                nxt_st.map      = plan_dacs('0);                     // RULE12
                if (st_ff.pwr_up && pins.sw[SW_ERASE])
                    nxt_st.erase = 1'b1;                             // RULE2
                if (st_ff.pwr_up && pins.master_reset_jumper)
                    nxt_st.erase = 1'b1;                             // RULE3
                nxt_st.pwr_up   = 1'b0;
                nxt_st.state    = st_run;
            end
            st_run:
            begin
                // reset pin falling: resample, and erase if the jumper is fitted
                if (st_ff.rin_prev && !pins.reset_in_n)
                begin
                    nxt_st.state = st_settle;                        // RULE1
                    nxt_st.cnt   = '0;
                    if (pins.master_reset_jumper)
                        nxt_st.erase = 1'b1;                         // RULE3
                end
            end
            default:
            begin
                nxt_st.state = st_settle;
                nxt_st.cnt   = '0;
            end
        endcase

        // registered so the ready output needs no decode after the flop
        nxt_st.ready = (nxt_st.state == st_run);

        // acceptance follows the image flag live, the jumper overrides it
        nxt_st.fw_ok     = st_ff.cap.firmware_upgrade_jumper | nvm_image_ok;    // RULE9
        nxt_st.step_axes = st_ff.cap.stepper_mode_jumper & st_ff.type_mask;    // RULE10

        // register writes; ignored until the snapshot exists
        if (wr_stb && st_ff.state == st_run)
        begin
            if (addr == REG_CTRL)
            begin
                // enable wins when both bits are written together
                if (wdata[CTRL_MOTOR_OFF])
                    nxt_st.motor_en = 1'b0;
                if (wdata[CTRL_SERVO_EN])
                    nxt_st.motor_en = 1'b1;                          // RULE11
            end
            else if (addr == REG_MTYPE)
            begin
                nxt_st.type_mask = wdata[AXES-1:0];                  // RULE10
            end
            else if (addr == REG_SINE)
            begin
                nxt_st.sine_mask = wdata[AXES-1:0];
                nxt_st.map       = plan_dacs(wdata[AXES-1:0]);       // RULE13
            end
        end

        // register reads, data the cycle after the strobe
        if (rd_stb)
        begin
            if (addr == REG_STATUS)
                nxt_st.rd = 32'({st_ff.state, st_ff.motor_en, st_ff.fw_ok, st_ff.cap});
            else if (addr == REG_CTRL)
                nxt_st.rd = 32'(st_ff.motor_en);
            else if (addr == REG_MTYPE)
                nxt_st.rd = 32'({st_ff.step_axes, st_ff.type_mask});
            else if (addr == REG_SINE)
                nxt_st.rd = 32'(st_ff.sine_mask);
            else if (addr == REG_AXES)
                nxt_st.rd = 32'({st_ff.map.borrowed, st_ff.map.addressable, st_ff.map.count});  // RULE14
            else if (addr == REG_DACMAP)
                nxt_st.rd = 32'(st_ff.map.second_dac);
            else
                nxt_st.rd = '0;                                      // unmapped reads zero
        end

        // colon prompt after an update, to the selected message port
        if (fw_update_done)
        begin
            nxt_st.prompt_v   = 1'b1;                                // RULE8
            nxt_st.prompt_usb = st_ff.msg_usb;                       // RULE8
        end
    end

    // state register; reset loads constants only
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            st_ff          <= '0;
            st_ff.state    <= st_settle;
            st_ff.pwr_up   <= 1'b1;
            st_ff.rin_prev <= 1'b1;
            st_ff.uart     <= '{xon_en: 1'b0, hwhs_en: 1'b0, rate: baud_19200, div: DIV_19200,
                                data_bits: FRAME_DATA_BITS, stop_bits: FRAME_STOP_BITS,
                                parity_en: FRAME_PARITY};
            st_ff.map.addressable <= '1;                             // RULE12
            st_ff.map.count       <= CNT_AX_W'(AXES);                // RULE12
            st_ff.map.second_dac  <= '{7: 3'h7, 6: 3'h6, 5: 3'h5, 4: 3'h4,
                                       3: 3'h3, 2: 3'h2, 1: 3'h1, 0: 3'h0};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from the state register, prompt_char tied to PROMPT_CHAR
    assign rdata          = st_ff.rd;
    assign uart_cfg       = st_ff.uart;
    assign msg_port_usb   = st_ff.msg_usb;
    assign nvm_erase_all  = st_ff.erase;
    assign fw_load_accept = st_ff.fw_ok;
    assign step_dir_axes  = st_ff.step_axes;
    assign motor_enable   = st_ff.motor_en;
    assign dac_map        = st_ff.map;
    assign prompt_valid   = st_ff.prompt_v;
    assign prompt_char    = PROMPT_CHAR;
    assign prompt_to_usb  = st_ff.prompt_usb;
    assign cfg_ready      = st_ff.ready;
endmodule // powerup_config_sampler

// >>> verif/powerup_config_sampler_chk.sv
`timescale 1ns/1ps
module powerup_config_sampler_chk
(
    input wire logic               clock,
    input wire logic               nrst,
    input wire cfg_pkg::pin_t      pins_raw,
    input wire logic               nvm_image_ok,
    input wire logic               fw_update_done,
    input wire cfg_pkg::uart_cfg_t uart_cfg,
    input wire logic               msg_port_usb,
    input wire logic               nvm_erase_all,
    input wire logic               fw_load_accept,
    input wire logic [7:0]         step_dir_axes,
    input wire cfg_pkg::dac_map_t  dac_map,
    input wire logic               prompt_valid,
    input wire logic [7:0]         prompt_char,
    input wire logic               cfg_ready
);
    import cfg_pkg::*;
    // one domain, so clock and reset are given once
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    chk_prompt_pulse: assert property (fw_update_done |=> prompt_valid && prompt_char == PROMPT_CHAR)
        else $error("no prompt after update");
    chk_prompt_quiet: assert property (!fw_update_done |=> !prompt_valid)
        else $error("prompt without update");
    chk_frame_fixed: assert property (uart_cfg.data_bits == 4'h8 && uart_cfg.stop_bits == 2'h1
        && !uart_cfg.parity_en) else $error("frame not 8N1");
    // divider must agree with the decoded rate whenever cfg_ready is high
    chk_rate_div: assert property (cfg_ready |-> uart_cfg.div == ((uart_cfg.rate == baud_1200) ? DIV_1200 :
        (uart_cfg.rate == baud_9600) ? DIV_9600 : (uart_cfg.rate == baud_38400) ? DIV_38400 :
        (uart_cfg.rate == baud_115200) ? DIV_115200 : DIV_19200)) else $error("divider off rate");
    chk_erase_single: assert property ($rose(nvm_erase_all) |=> !nvm_erase_all [*3])
        else $error("erase pulse too long");
    chk_cfg_hold: assert property (cfg_ready && $past(cfg_ready) |-> $stable(uart_cfg) && $stable(msg_port_usb))
        else $error("config moved in run");
    chk_fw_accept: assert property (cfg_ready && $past(cfg_ready) |->
        fw_load_accept == ($past(nvm_image_ok) || pins_raw.firmware_upgrade_jumper)) else $error("reload gate");
    chk_axis_count: assert property (dac_map.count == 4'(AXES - $countones(dac_map.borrowed))
        && dac_map.addressable == ~dac_map.borrowed) else $error("axis count off");
    chk_step_jumper: assert property (cfg_ready && $past(cfg_ready, 2) |->
        (step_dir_axes & ~pins_raw.stepper_mode_jumper) == 8'h00) else $error("step without jumper");
endmodule // powerup_config_sampler_chk

bind powerup_config_sampler powerup_config_sampler_chk chk_u (.clock(clock), .nrst(nrst), .pins_raw(pins_raw),
    .nvm_image_ok(nvm_image_ok), .fw_update_done(fw_update_done), .uart_cfg(uart_cfg),
    .msg_port_usb(msg_port_usb), .nvm_erase_all(nvm_erase_all), .fw_load_accept(fw_load_accept),
    .step_dir_axes(step_dir_axes), .dac_map(dac_map), .prompt_valid(prompt_valid),
    .prompt_char(prompt_char), .cfg_ready(cfg_ready));

// >>> verif/switch_panel.sv
`timescale 1ns/1ps
module switch_panel
(
    input  wire logic [9:0]         sw_set,
    input  wire logic [7:0]         step_set,
    input  wire logic               erase_fit,
    input  wire logic               upg_fit,
    input  wire logic               moff_fit,
    input  wire logic               rst_pin,
    input  wire cfg_pkg::uart_cfg_t uart_cfg,
    output cfg_pkg::pin_t           pins_raw,
    output logic                    frame_ok
);
    import cfg_pkg::*;
    // switches and jumpers are hard levels, never floating
    assign pins_raw.sw                      = sw_set;
    assign pins_raw.stepper_mode_jumper     = step_set;
    assign pins_raw.master_reset_jumper     = erase_fit;
    assign pins_raw.firmware_upgrade_jumper = upg_fit;
    assign pins_raw.motor_off_select        = moff_fit;
    assign pins_raw.reset_in_n              = rst_pin;
    // host talks only 8N1; any other framing means no link
    assign frame_ok = uart_cfg.data_bits == 4'h8 && uart_cfg.stop_bits == 2'h1 && !uart_cfg.parity_en;
endmodule // switch_panel

// >>> verif/tb_powerup_config_sampler.sv
`timescale 1ns/1ps
module tb_powerup_config_sampler;
    import cfg_pkg::*;
    logic clock, nrst, rst_pin, erase_fit, upg_fit, moff_fit, nvm_image_ok, fw_update_done, wr_stb, rd_stb;
    logic [9:0]  sw_set;      // installer switches
    logic [7:0]  step_set;    // stepper jumpers
    logic [5:0]  addr;
    logic [31:0] wdata, rdata, d, s, r, m;
    logic [7:0]  eb;          // expected borrowed mask
    logic [23:0] esd;         // expected second dac map
    pin_t        pins_raw;
    uart_cfg_t   uart_cfg;
    dac_map_t    dac_map;
    logic        msg_port_usb, nvm_erase_all, fw_load_accept, motor_enable, prompt_valid, prompt_to_usb;
    logic        cfg_ready, frame_ok;
    logic [7:0]  step_dir_axes, prompt_char;
    int          error_cnt, total_checks, cyc, erase_n, base, seed;
    int          rates [5] = '{1200, 9600, 19200, 38400, 115200};

    switch_panel pnl_u (.sw_set(sw_set), .step_set(step_set), .erase_fit(erase_fit), .upg_fit(upg_fit),
        .moff_fit(moff_fit), .rst_pin(rst_pin), .uart_cfg(uart_cfg), .pins_raw(pins_raw), .frame_ok(frame_ok));
    powerup_config_sampler dut_u (.clock(clock), .nrst(nrst), .pins_raw(pins_raw), .nvm_image_ok(nvm_image_ok),
        .fw_update_done(fw_update_done), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata(rdata), .uart_cfg(uart_cfg), .msg_port_usb(msg_port_usb), .nvm_erase_all(nvm_erase_all),
        .fw_load_accept(fw_load_accept), .step_dir_axes(step_dir_axes), .motor_enable(motor_enable),
        .dac_map(dac_map), .prompt_valid(prompt_valid), .prompt_char(prompt_char),
        .prompt_to_usb(prompt_to_usb), .cfg_ready(cfg_ready));

    initial
    begin
        clock = 0;
        forever #4 clock = ~clock;
    end

    // erase pulses counted, plus a hang guard
    always @(posedge clock)
    begin
        cyc++;
        if (nvm_erase_all === 1'b1) erase_n++;
        if (cyc > 5000)
        begin
            error_cnt++;
            test_done();
        end
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] v);
        @(posedge clock);
        addr <= a; wdata <= v; wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [5:0] a, output logic [31:0] v);
        @(posedge clock);
        addr <= a; rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        #1 v = rdata;
    endtask

    // bounded wait for run phase, then let outputs settle
    task automatic wait_ready();
        int k;
        k = 0;
        while (cfg_ready !== 1'b1 && k < 100)
        begin
            @(posedge clock);
            #1 k++;
        end
        repeat (3) @(posedge clock);
        #1;
    endtask

    // everything that a fresh sample of switches w should give
    task automatic chk_cfg(input logic [9:0] w);
        int i;
        case ({w[3], w[4], w[5]})
            3'h6: i = 0;
            3'h4: i = 1;
            3'h1: i = 3;
            3'h3: i = 4;
            default: i = 2; // unlisted pattern lands on default
        endcase
        cmp(uart_cfg.xon_en, w[1]);
        cmp(uart_cfg.hwhs_en, w[2]);
        cmp(uart_cfg.rate, i);
        cmp(uart_cfg.div, 125000000 / rates[i]);
        cmp(msg_port_usb, w[9]);
        cmp(motor_enable, !moff_fit);
        cmp(fw_load_accept, upg_fit | nvm_image_ok);
        cmp(step_dir_axes, 0);
        cmp({dac_map.count, dac_map.borrowed}, 32'h800);
        cmp(frame_ok, 1);
    endtask

    initial
    begin
        {nrst, fw_update_done, wr_stb, rd_stb, addr, wdata, sw_set, step_set} = '0;
        {erase_fit, upg_fit, moff_fit, nvm_image_ok} = '0;
        rst_pin = 1'b1;
        seed = 96217;
        // one power-up per rate pattern, the rest random
        for (int p = 0; p < 8; p++)
        begin
            s = $random(seed);
            r = $random(seed);
            {s[3], s[4], s[5]} = p[2:0];
            @(posedge clock);
            nrst <= 1'b0; sw_set <= s[9:0]; step_set <= r[7:0];
            {erase_fit, upg_fit, moff_fit, nvm_image_ok} <= r[11:8];
            repeat (10) @(posedge clock);
            nrst <= 1'b1;
            base = erase_n;
            wait_ready();
            cmp(erase_n - base, s[0] | r[11]);
            chk_cfg(s[9:0]);
            sw_set <= ~s[9:0];
            repeat (8) @(posedge clock);
            #1 chk_cfg(s[9:0]);
            base = erase_n;
            @(posedge clock);
            rst_pin <= 1'b0;
            repeat (8) @(posedge clock);
            rst_pin <= 1'b1;
            wait_ready();
            cmp(erase_n - base, erase_fit);
            chk_cfg(~s[9:0]);
        end
        rd(REG_STATUS, d);
        cmp(d & 32'h033FFFFF, {8'h02, 2'h0, pins_raw});
        m = $random(seed);
        wr(REG_MTYPE, m);
        repeat (2) @(posedge clock);
        #1 cmp(step_dir_axes, m[7:0] & step_set);
        rd(REG_MTYPE, d);
        cmp(d, {16'h0, m[7:0] & step_set, m[7:0]});
        // off, on, off, both set (enable wins), off
        foreach (rates[j])
        begin
            wr(REG_CTRL, {30'h0, !j[0] || j == 3, j[0]});
            cmp(motor_enable, j[0]);
        end
        for (int j = 0; j < 5; j++)
        begin
            m = (j == 0) ? 32'h1 : $random(seed);
            wr(REG_SINE, m);
            eb = 8'h00;
            for (int i = 0; i < 8; i++) esd[3 * i +: 3] = i[2:0];
            for (int i = 0; i < 8; i++)
                if (m[i] && !eb[i])
                    for (int k = 7; k > i; k--)
                        if (!eb[k] && !m[k] && esd[3 * i +: 3] == i[2:0])
                        begin
                            eb[k] = 1'b1;
                            esd[3 * i +: 3] = k[2:0];
                        end
            cmp(dac_map.second_dac, esd);
            rd(REG_DACMAP, d);
            cmp(d, esd);
            rd(REG_AXES, d);
            cmp(d, {eb, ~eb, 4'(8 - $countones(eb))});
        end
        rd(6'h3C, d);
        cmp(d, 0);
        // two updates back to back, one prompt each
        @(posedge clock);
        fw_update_done <= 1'b1;
        @(posedge clock);
        #1 cmp({prompt_valid, prompt_to_usb, prompt_char}, {1'b1, msg_port_usb, 8'h3A});
        @(posedge clock);
        fw_update_done <= 1'b0;
        #1 cmp({prompt_valid, prompt_to_usb}, {1'b1, msg_port_usb});
        @(posedge clock);
        #1 cmp(prompt_valid, 0);
        test_done();
    end
endmodule // tb_powerup_config_sampler
